// ===== logic/frc_flash_regcmd.sv
`timescale 1ns/100ps
`default_nettype none
module frc_flash_regcmd
   import frc_pkg::*;
#(
   parameter int UPDATE_CYCLES = FRC_UPDATE_CYCLES
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic lane_zero,
   input wire logic lane_four,
   input wire logic update_fail,
   output logic lane_one,
   output logic lane_one_oe,
   output logic lane_five,
   output logic lane_five_oe,
   output logic [7:0] status_one,
   output logic [7:0] status_two,
   output logic [7:0] config_one,
   output logic [7:0] config_two,
   output logic [7:0] bank_one,
   output logic [7:0] bank_two,
   output logic [FRC_BANK_BITS-1:0] addr_high_one,
   output logic [FRC_BANK_BITS-1:0] addr_high_two,
   output logic ext_addr_one,
   output logic ext_addr_two
);
   localparam logic [15:0] UPD_LAST = 16'(UPDATE_CYCLES - 1);

   typedef struct packed {
      logic sck_prev;
      logic cs_prev;
      frc_phase_type phase;
      logic [2:0] bit_idx;
      logic [2:0] byte_cnt;
      logic [FRC_NUM_IF-1:0][7:0] in_sr;
      logic [FRC_NUM_IF-1:0][7:0] first_byte;
      logic [FRC_NUM_IF-1:0][7:0] second_byte;
      logic [FRC_NUM_IF-1:0][7:0] status;
      logic [FRC_NUM_IF-1:0][7:0] cfg;
      logic [FRC_NUM_IF-1:0][7:0] bank;
      logic [FRC_NUM_IF-1:0][7:0] pend_status;
      logic [FRC_NUM_IF-1:0][7:0] pend_cfg;
      logic [FRC_NUM_IF-1:0] pend_cfg_en;
      logic [FRC_NUM_IF-1:0] updating;
      logic [15:0] upd_cnt;
      logic bank_window;
      logic [FRC_NUM_IF-1:0][7:0] out_sr;
      logic out_en;
   } frc_state_type;

   frc_state_type q, d;

   logic [3:0] sync_out;
   logic cs_s, sck_s;
   logic [FRC_NUM_IF-1:0] din;
   logic sck_rise, sck_fall, cs_fall, cs_rise;
   logic upd_done, at8, at16, at24, data_byte_in;

   function automatic frc_phase_type frc_decode(input logic [7:0] cmd);
      case (cmd)
         FRC_CMD_READ_CONFIG: return FRC_PH_READ_CFG;
         FRC_CMD_BANK_READ: return FRC_PH_READ_BANK;
         FRC_CMD_BANK_WRITE: return FRC_PH_WRITE_BANK;
         FRC_CMD_BANK_ACCESS_PREFIX: return FRC_PH_BANK_ACCESS;
         FRC_CMD_WRITE_REGISTERS: return FRC_PH_WRITE_REGS;
         FRC_CMD_WRITE_ENABLE: return FRC_PH_WRITE_ENABLE;
         FRC_CMD_WRITE_DISABLE: return FRC_PH_WRITE_DISABLE;
         default: return FRC_PH_OTHER;
      endcase
   endfunction

   // True when the frame ended exactly on a byte boundary after want bytes
   function automatic logic frc_exact(input logic [2:0] bytes, input logic [2:0] bits,
                                      input logic [2:0] want);
      return (bits == 3'h0) && (bytes == want);
   endfunction

   frc_sync #(
      .WIDTH(4),
      .RESET_VALUE(4'h1)
   ) u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .din({lane_four, lane_zero, sck, cs_n}),
      .dout(sync_out)
   );

   assign cs_s = sync_out[0];
   assign sck_s = sync_out[1];
   assign din = sync_out[3:2];
   assign sck_rise = sck_s && !q.sck_prev;
   assign sck_fall = !sck_s && q.sck_prev;
   assign cs_fall = !cs_s && q.cs_prev;
   assign cs_rise = cs_s && !q.cs_prev;
   assign upd_done = (|q.updating) && (q.upd_cnt == UPD_LAST);
   assign at8 = frc_exact(q.byte_cnt, q.bit_idx, 3'h1);
   assign at16 = frc_exact(q.byte_cnt, q.bit_idx, 3'h2);
   assign at24 = frc_exact(q.byte_cnt, q.bit_idx, 3'h3);
   assign data_byte_in = q.byte_cnt >= 3'h2;

   always_comb begin
      d = q;
      d.sck_prev = sck_s;
      d.cs_prev = cs_s;

      if (|q.updating) begin
         d.upd_cnt = q.upd_cnt + 16'h0001;
      end
      // update completes, busy and latch drop
      if (upd_done) begin
         d.upd_cnt = '0;
         d.updating = '0;
         for (int i = 0; i < FRC_NUM_IF; i++) begin
            if (q.updating[i]) begin
               if (update_fail) begin
                  d.status[i][FRC_SR_PERR_BIT] = 1'b1;
               end else begin
                  d.status[i] = (q.status[i] & ~FRC_SR_WRITE_MASK) |
                                (q.pend_status[i] & FRC_SR_WRITE_MASK);
                  if (q.pend_cfg_en[i]) begin
                     d.cfg[i] = q.pend_cfg[i];
                  end
               end
               d.status[i][FRC_SR_WIP_BIT] = 1'b0;
               d.status[i][FRC_SR_WEL_BIT] = 1'b0;
            end
         end
      end

      if (cs_fall) begin
         d.phase = FRC_PH_CMD;
         d.bit_idx = 3'h0;
         d.byte_cnt = 3'h0;
      end else if (!cs_s && sck_rise) begin
         d.bit_idx = q.bit_idx + 3'h1;
         // each interface shifts its own input lane
         for (int i = 0; i < FRC_NUM_IF; i++) begin
            d.in_sr[i] = {q.in_sr[i][6:0], din[i]};
         end
         if (q.bit_idx == 3'h7) begin
            if (q.byte_cnt != 3'h7) begin
               d.byte_cnt = q.byte_cnt + 3'h1;
            end
            // decode takes no notice of busy state
            if (q.phase == FRC_PH_CMD) begin
               d.phase = frc_decode({q.in_sr[0][6:0], din[0]});
            end
            // data taken from lanes zero and four
            for (int i = 0; i < FRC_NUM_IF; i++) begin
               if (q.byte_cnt == 3'h1) begin
                  d.first_byte[i] = {q.in_sr[i][6:0], din[i]};
               end else if (q.byte_cnt == 3'h2) begin
                  d.second_byte[i] = {q.in_sr[i][6:0], din[i]};
               end
            end
         end
      end

      // output changes on falling edge, msb first
      if (!cs_s && sck_fall &&
          (q.phase == FRC_PH_READ_CFG || q.phase == FRC_PH_READ_BANK)) begin
         d.out_en = 1'b1;
         for (int i = 0; i < FRC_NUM_IF; i++) begin
            if (q.bit_idx == 3'h0) begin
               d.out_sr[i] = (q.phase == FRC_PH_READ_CFG) ? q.cfg[i] : q.bank[i];
            end else begin
               d.out_sr[i] = {q.out_sr[i][6:0], 1'b0};
            end
         end
      end
      if (cs_s) begin
         d.out_en = 1'b0;
      end

      if (cs_rise) begin
         // window opens only on prefix, else closes
         d.bank_window = (q.phase == FRC_PH_BANK_ACCESS) && at8;
         unique case (q.phase)
            FRC_PH_WRITE_ENABLE: begin
               if (at8) begin
                  for (int i = 0; i < FRC_NUM_IF; i++) begin
                     d.status[i][FRC_SR_WEL_BIT] = 1'b1;
                  end
               end
            end
            FRC_PH_WRITE_DISABLE: begin
               for (int i = 0; i < FRC_NUM_IF; i++) begin
                  if (at8 && !q.status[i][FRC_SR_WIP_BIT]) begin
                     d.status[i][FRC_SR_WEL_BIT] = 1'b0;
                  end
               end
            end
            FRC_PH_WRITE_BANK: begin
               // whole byte, no latch, flags untouched
               if (data_byte_in) begin
                  d.bank = q.first_byte;
               end
            end
            FRC_PH_WRITE_REGS: begin
               if (q.bank_window) begin
                  // low bank bits only, no latch needed
                  if (data_byte_in) begin
                     for (int i = 0; i < FRC_NUM_IF; i++) begin
                        d.bank[i][FRC_BANK_BITS-1:0] = q.first_byte[i][FRC_BANK_BITS-1:0];
                     end
                  end
               end else begin
                  for (int i = 0; i < FRC_NUM_IF; i++) begin
                     // start update on legal length with latch
                     if ((at16 || at24) && q.status[i][FRC_SR_WEL_BIT] &&
                         !q.status[i][FRC_SR_WIP_BIT]) begin
                        d.pend_status[i] = q.first_byte[i];
                        d.pend_cfg[i] = q.second_byte[i];
                        d.pend_cfg_en[i] = at24;
                        d.updating[i] = 1'b1;
                        d.status[i][FRC_SR_WIP_BIT] = 1'b1;
                        d.upd_cnt = '0;
                     end
                  end
               end
            end
            FRC_PH_CMD, FRC_PH_READ_CFG, FRC_PH_READ_BANK, FRC_PH_BANK_ACCESS,
            FRC_PH_OTHER: begin
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         q <= '0;
         q.cs_prev <= 1'b1;
         q.status <= {FRC_NUM_IF{FRC_SR_RESET}};
         q.cfg <= {FRC_NUM_IF{FRC_CR_RESET}};
         q.bank <= {FRC_NUM_IF{FRC_BAR_RESET}};
      end else begin
         q <= d;
      end
   end

   assign lane_one = q.out_sr[0][7];
   assign lane_five = q.out_sr[1][7];
   assign lane_one_oe = q.out_en;
   assign lane_five_oe = q.out_en;
   assign status_one = q.status[0];
   assign status_two = q.status[1];
   assign config_one = q.cfg[0];
   assign config_two = q.cfg[1];
   assign bank_one = q.bank[0];
   assign bank_two = q.bank[1];
   assign ext_addr_one = q.bank[0][FRC_BAR_EXT_BIT];
   assign ext_addr_two = q.bank[1][FRC_BAR_EXT_BIT];
   // bank bits feed high address in three-byte mode
   assign addr_high_one = ext_addr_one ? '0 : q.bank[0][FRC_BANK_BITS-1:0];
   assign addr_high_two = ext_addr_two ? '0 : q.bank[1][FRC_BANK_BITS-1:0];

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   sequence seq_wrr_start;
      cs_rise && q.phase == FRC_PH_WRITE_REGS && !q.bank_window &&
      q.status[0][FRC_SR_WEL_BIT] && !q.status[0][FRC_SR_WIP_BIT] && (at16 || at24);
   endsequence
   sequence seq_busy_hold;
      q.status[0][FRC_SR_WIP_BIT] [*8];
   endsequence
   chk_wel_set_write_enable_cmd: assert property (
      cs_rise && q.phase == FRC_PH_WRITE_ENABLE && at8 |=> q.status[1][FRC_SR_WEL_BIT])
      else $error("enable command did not set latch");
   chk_wel_clear_write_disable_cmd: assert property (
      cs_rise && q.phase == FRC_PH_WRITE_DISABLE && at8 && !q.status[0][FRC_SR_WIP_BIT]
      |=> !q.status[0][FRC_SR_WEL_BIT])
      else $error("disable command did not clear latch");
   chk_write_disable_cmd_busy_ignored: assert property (
      cs_rise && q.phase == FRC_PH_WRITE_DISABLE && q.status[0][FRC_SR_WIP_BIT] &&
      q.status[0][FRC_SR_WEL_BIT] && !upd_done |=> q.status[0][FRC_SR_WEL_BIT])
      else $error("disable command acted while busy");
   chk_bank_write_load: assert property (
      cs_rise && q.phase == FRC_PH_WRITE_BANK && data_byte_in
      |=> q.bank[0] == $past(q.first_byte[0]))
      else $error("bank write did not load bank register");
   chk_bank_write_flags: assert property (
      cs_rise && q.phase == FRC_PH_WRITE_BANK && !upd_done
      |=> q.status == $past(q.status))
      else $error("bank write disturbed status flags");
   chk_window_low_bits: assert property (
      cs_rise && q.phase == FRC_PH_WRITE_REGS && q.bank_window && data_byte_in
      |=> q.bank[0][1:0] == $past(q.first_byte[0][1:0]) &&
          q.bank[0][7:2] == $past(q.bank[0][7:2]) && !q.updating[0])
      else $error("prefix sequence loaded bank wrongly");
   chk_window_closes: assert property (
      cs_rise && q.phase != FRC_PH_BANK_ACCESS |=> !q.bank_window)
      else $error("bank window stayed open");
   chk_wrr_busy_hold: assert property (
      seq_wrr_start |=> seq_busy_hold)
      else $error("busy bit dropped early during update");
   // An enable frame ending in the same cycle wins over the latch clear
   chk_wrr_done_clears: assert property (
      upd_done && q.updating[0] && !(cs_rise && q.phase == FRC_PH_WRITE_ENABLE && at8)
      |=> !q.status[0][FRC_SR_WIP_BIT] && !q.status[0][FRC_SR_WEL_BIT])
      else $error("update end did not clear busy and latch");
   chk_wrr_needs_wel: assert property (
      cs_rise && q.phase == FRC_PH_WRITE_REGS && !q.bank_window &&
      !q.status[0][FRC_SR_WEL_BIT] && !q.status[0][FRC_SR_WIP_BIT]
      |=> !q.status[0][FRC_SR_WIP_BIT])
      else $error("register write ran without latch");
   chk_wrr_bad_length: assert property (
      cs_rise && q.phase == FRC_PH_WRITE_REGS && !q.bank_window && !(at16 || at24) &&
      !q.status[0][FRC_SR_WIP_BIT] |=> !q.status[0][FRC_SR_WIP_BIT])
      else $error("register write of wrong length ran");
   chk_fail_flag: assert property (
      upd_done && update_fail && q.updating[0] |=> q.status[0][FRC_SR_PERR_BIT])
      else $error("failed update did not flag error");
   chk_read_cfg_out: assert property (
      !cs_s && sck_fall && q.phase == FRC_PH_READ_CFG && q.bit_idx == 3'h0
      |=> lane_one == $past(q.cfg[0][7]) && lane_five == $past(q.cfg[1][7]) && lane_one_oe)
      else $error("config byte not driven on output lanes");
   chk_read_bank_out: assert property (
      !cs_s && sck_fall && q.phase == FRC_PH_READ_BANK && q.bit_idx == 3'h0
      |=> lane_one == $past(q.bank[0][7]) && lane_five_oe)
      else $error("bank byte not driven on output lane");
   chk_ext_addr_high: assert property (
      cs_rise && q.phase == FRC_PH_WRITE_BANK && data_byte_in &&
      !q.first_byte[1][FRC_BAR_EXT_BIT]
      |=> addr_high_two == $past(q.first_byte[1][FRC_BANK_BITS-1:0]) && !ext_addr_two)
      else $error("high address not taken from bank bits");
endmodule
`default_nettype wire

// ===== logic/frc_pkg.sv
`default_nettype none
package frc_pkg;
   localparam int FRC_NUM_IF = 2;
   localparam int FRC_BANK_BITS = 2;

   localparam logic [7:0] FRC_CMD_READ_CONFIG = 8'h35;
   localparam logic [7:0] FRC_CMD_BANK_READ = 8'h16;
   localparam logic [7:0] FRC_CMD_BANK_WRITE = 8'h17;
   localparam logic [7:0] FRC_CMD_BANK_ACCESS_PREFIX = 8'hb9;
   localparam logic [7:0] FRC_CMD_WRITE_REGISTERS = 8'h01;
   localparam logic [7:0] FRC_CMD_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] FRC_CMD_WRITE_DISABLE = 8'h04;

   localparam int FRC_SR_WIP_BIT = 0;
   localparam int FRC_SR_WEL_BIT = 1;
   localparam int FRC_SR_EERR_BIT = 5;
   localparam int FRC_SR_PERR_BIT = 6;
   localparam int FRC_SR_STATUS_WRITE_DISABLE_BIT_BIT = 7;
   localparam int FRC_CR_QUAD_BIT = 1;
   localparam int FRC_BAR_EXT_BIT = 7;

   // Bits of status register one that a register write may change
   localparam logic [7:0] FRC_SR_WRITE_MASK = 8'h9c;
   localparam logic [7:0] FRC_SR_RESET = 8'h00;
   localparam logic [7:0] FRC_CR_RESET = 8'h00;
   localparam logic [7:0] FRC_BAR_RESET = 8'h00;

   localparam int FRC_CLOCK_HZ = 25_000_000;
   localparam int FRC_CLOCK_PERIOD_NS = 1_000_000_000 / FRC_CLOCK_HZ;
   localparam int FRC_UPDATE_TIME_NS = 4000;
   localparam int FRC_UPDATE_CYCLES =
      (FRC_UPDATE_TIME_NS + FRC_CLOCK_PERIOD_NS - 1) / FRC_CLOCK_PERIOD_NS;

   typedef enum logic [3:0] {
      FRC_PH_CMD = 4'h0,
      FRC_PH_READ_CFG = 4'h1,
      FRC_PH_READ_BANK = 4'h2,
      FRC_PH_WRITE_REGS = 4'h3,
      FRC_PH_WRITE_BANK = 4'h4,
      FRC_PH_WRITE_ENABLE = 4'h5,
      FRC_PH_WRITE_DISABLE = 4'h6,
      FRC_PH_BANK_ACCESS = 4'h7,
      FRC_PH_OTHER = 4'h8
   } frc_phase_type;
endpackage
`default_nettype wire

// ===== logic/frc_sync.sv
`timescale 1ns/100ps
`default_nettype none
module frc_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } frc_sync_state_type;

   frc_sync_state_type q;
   frc_sync_state_type d;

   always_comb begin
      d = q;
      d.stage1 = din;
      d.stage2 = q.stage1;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         q.stage1 <= RESET_VALUE;
         q.stage2 <= RESET_VALUE;
      end else begin
         q <= d;
      end
   end

   assign dout = q.stage2;
endmodule
`default_nettype wire

// ===== verif/frc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module frc_host_model (
   input wire logic clock,
   output logic cs_n,
   output logic sck,
   output logic lane_zero,
   output logic lane_four,
   input wire logic lane_one,
   input wire logic lane_five
);
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      lane_zero = 1'b0;
      lane_four = 1'b0;
   end

   // Half of a 320 ns serial clock period
   task automatic half();
      repeat (4) @(negedge clock);
   endtask

   // Mode 0 frame: tx is msb aligned, nbits driven, then nread bits sampled
   task automatic frame(input logic [31:0] tx0, input logic [31:0] tx4, input int nbits,
         input int nread, output logic [15:0] rx1, output logic [15:0] rx5);
      rx1 = '0;
      rx5 = '0;
      @(negedge clock);
      cs_n = 1'b0;
      half();
      for (int i = 0; i < nbits + nread; i++) begin
         if (i < nbits) begin
            lane_zero = tx0[31-i];
            lane_four = tx4[31-i];
         end else begin
            // Lines not carrying data toggle so a stale value is never read as good
            lane_zero = ~lane_zero;
            lane_four = ~lane_four;
         end
         half();
         sck = 1'b1;
         half();
         if (i >= nbits) begin
            rx1 = {rx1[14:0], lane_one};
            rx5 = {rx5[14:0], lane_five};
         end
         sck = 1'b0;
      end
      half();
      cs_n = 1'b1;
      lane_zero = ~lane_zero;
      lane_four = ~lane_four;
      repeat (8) @(negedge clock);
   endtask
endmodule
`default_nettype wire

// ===== verif/tb_frc_flash_regcmd.sv
`timescale 1ns/100ps
`default_nettype none
module tb_frc_flash_regcmd
   import frc_pkg::*;
;
   localparam int UPD = 400;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic update_fail = 1'b0;
   logic cs_n, sck, lane_zero, lane_four;
   logic lane_one, lane_one_oe, lane_five, lane_five_oe;
   logic [7:0] status_one, status_two, config_one, config_two, bank_one, bank_two;
   logic [FRC_BANK_BITS-1:0] addr_high_one, addr_high_two;
   logic ext_addr_one, ext_addr_two;
   logic [15:0] rx1, rx5;
   int fails = 0;
   int n_compared = 0;

   always #20 clock = ~clock;

   logic line_one, line_five;

   // Released output lanes show the inverse so a read without drive fails
   assign line_one = lane_one_oe ? lane_one : ~lane_one;
   assign line_five = lane_five_oe ? lane_five : ~lane_five;

   frc_host_model host (.clock(clock), .cs_n(cs_n), .sck(sck), .lane_zero(lane_zero),
      .lane_four(lane_four), .lane_one(line_one), .lane_five(line_five));

   frc_flash_regcmd #(.UPDATE_CYCLES(UPD)) dut (.clock(clock), .rst_n(rst_n), .cs_n(cs_n),
      .sck(sck), .lane_zero(lane_zero), .lane_four(lane_four), .update_fail(update_fail),
      .lane_one(lane_one), .lane_one_oe(lane_one_oe), .lane_five(lane_five),
      .lane_five_oe(lane_five_oe), .status_one(status_one), .status_two(status_two),
      .config_one(config_one), .config_two(config_two), .bank_one(bank_one),
      .bank_two(bank_two), .addr_high_one(addr_high_one), .addr_high_two(addr_high_two),
      .ext_addr_one(ext_addr_one), .ext_addr_two(ext_addr_two));

   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic cmd(input logic [7:0] c, input logic [15:0] d0, input logic [15:0] d4,
         input int nbits, input int nread);
      host.frame({c, d0, 8'h00}, {c, d4, 8'h00}, nbits, nread, rx1, rx5);
   endtask

   task automatic idle();
      repeat (UPD) @(negedge clock);
   endtask

   initial begin
      #1_000_000;
      fails++;
      finish_test();
   end

   initial begin
      repeat (20) @(negedge clock);
      rst_n = 1'b1;
      repeat (4) @(negedge clock);
      check({status_one, status_two}, {FRC_SR_RESET, FRC_SR_RESET}, "status reset");
      check({config_one, config_two}, {FRC_CR_RESET, FRC_CR_RESET}, "config reset");
      check({bank_one, bank_two}, {FRC_BAR_RESET, FRC_BAR_RESET}, "bank reset");
      cmd(FRC_CMD_BANK_WRITE, 16'h8300, 16'h0200, 16, 0);
      check({bank_one, bank_two}, 16'h8302, "bank write");
      check({10'h000, ext_addr_one, ext_addr_two, addr_high_one, addr_high_two},
         16'h0022, "high address");
      check({status_one, status_two}, 16'h0000, "bank write flags");
      cmd(FRC_CMD_BANK_READ, 16'h0000, 16'h0000, 8, 16);
      check(rx1, 16'h8383, "bank read one");
      check(rx5, 16'h0202, "bank read two");
      check({14'h0000, lane_one_oe, lane_five_oe}, 16'h0000, "output released");
      cmd(FRC_CMD_WRITE_ENABLE, 16'h0000, 16'h0000, 9, 0);
      check({status_one, status_two}, 16'h0000, "long enable");
      cmd(FRC_CMD_WRITE_ENABLE, 16'h0000, 16'h0000, 8, 0);
      check({status_one, status_two}, 16'h0202, "enable");
      cmd(FRC_CMD_WRITE_DISABLE, 16'h0000, 16'h0000, 9, 0);
      check({status_one, status_two}, 16'h0202, "long disable");
      cmd(FRC_CMD_WRITE_DISABLE, 16'h0000, 16'h0000, 8, 0);
      check({status_one, status_two}, 16'h0000, "disable");
      cmd(FRC_CMD_WRITE_REGISTERS, 16'h1c04, 16'h0c08, 24, 0);
      idle();
      check({status_one, status_two}, 16'h0000, "write without latch");
      cmd(FRC_CMD_WRITE_ENABLE, 16'h0000, 16'h0000, 8, 0);
      cmd(FRC_CMD_WRITE_REGISTERS, 16'h1c04, 16'h0c08, 20, 0);
      idle();
      check({status_one, status_two}, 16'h0202, "cancelled write");
      check({config_one, config_two}, 16'h0000, "cancelled config");
      cmd(FRC_CMD_WRITE_REGISTERS, 16'h1c04, 16'h0c08, 24, 0);
      check({15'h0000, status_one[FRC_SR_WIP_BIT]}, 16'h0001, "busy");
      cmd(FRC_CMD_WRITE_DISABLE, 16'h0000, 16'h0000, 8, 0);
      check({15'h0000, status_one[FRC_SR_WEL_BIT]}, 16'h0001, "disable while busy");
      cmd(FRC_CMD_READ_CONFIG, 16'h0000, 16'h0000, 8, 16);
      check({rx1[7:0], rx5[7:0]}, 16'h0000, "config read while busy");
      idle();
      check({status_one, status_two}, 16'h1c0c, "status written");
      check({config_one, config_two}, 16'h0408, "config written");
      cmd(FRC_CMD_READ_CONFIG, 16'h0000, 16'h0000, 8, 16);
      check(rx1, 16'h0404, "config read one");
      check(rx5, 16'h0808, "config read two");
      // quad bit clear, short form allowed
      cmd(FRC_CMD_WRITE_ENABLE, 16'h0000, 16'h0000, 8, 0);
      cmd(FRC_CMD_WRITE_REGISTERS, 16'h0400, 16'h1000, 16, 0);
      idle();
      check({status_one, status_two}, 16'h0410, "short write");
      check({config_one, config_two}, 16'h0408, "short keeps config");
      // prefix while idle, no enable in between
      cmd(FRC_CMD_BANK_ACCESS_PREFIX, 16'h0000, 16'h0000, 8, 0);
      cmd(FRC_CMD_WRITE_REGISTERS, 16'hfeff, 16'h01ff, 24, 0);
      check({bank_one, bank_two}, 16'h8201, "prefix bank load");
      check({status_one, status_two}, 16'h0410, "prefix keeps status");
      cmd(FRC_CMD_WRITE_REGISTERS, 16'h0000, 16'h0000, 16, 0);
      idle();
      check({bank_one, bank_two}, 16'h8201, "window closed");
      check({status_one, status_two}, 16'h0410, "closed write refused");
      cmd(FRC_CMD_BANK_ACCESS_PREFIX, 16'h0000, 16'h0000, 8, 0);
      cmd(FRC_CMD_WRITE_ENABLE, 16'h0000, 16'h0000, 8, 0);
      cmd(FRC_CMD_WRITE_REGISTERS, 16'h0800, 16'h0800, 16, 0);
      idle();
      check({status_one, status_two}, 16'h0808, "other command closes");
      check({bank_one, bank_two}, 16'h8201, "bank kept");
      // an unknown command also closes the window
      cmd(FRC_CMD_WRITE_ENABLE, 16'h0000, 16'h0000, 8, 0);
      cmd(FRC_CMD_BANK_ACCESS_PREFIX, 16'h0000, 16'h0000, 8, 0);
      cmd(8'h00, 16'h0000, 16'h0000, 8, 0);
      cmd(FRC_CMD_WRITE_REGISTERS, 16'h0c00, 16'h0400, 16, 0);
      idle();
      check({status_one, status_two}, 16'h0c04, "unknown command closes");
      check({bank_one, bank_two}, 16'h8201, "bank kept after unknown");
      cmd(FRC_CMD_WRITE_ENABLE, 16'h0000, 16'h0000, 8, 0);
      update_fail = 1'b1;
      cmd(FRC_CMD_WRITE_REGISTERS, 16'h0000, 16'h0000, 16, 0);
      idle();
      update_fail = 1'b0;
      check({14'h0000, status_one[FRC_SR_PERR_BIT], status_two[FRC_SR_PERR_BIT]},
         16'h0003, "program error");
      finish_test();
   end
endmodule
`default_nettype wire
